// >>> src/mcs_pkg.sv
package mcs_pkg;

    // =====================================================================
    // widths
    localparam int DATA_W = 64;
    localparam int KEEP_W = 8;
    localparam int IFG_W = 8;
    // user vector is one bit, or 128 bits with timestamping built in
    localparam int TUSER_W_PLAIN = 1;
    localparam int TUSER_W_PTP = 128;
    localparam int UNDERRUN_BIT = 0;

    // =====================================================================
    // values after reset and counts
    localparam logic [KEEP_W-1:0] KEEP_FULL = 8'hFF;
    localparam logic [KEEP_W-1:0] KEEP_NONE = 8'h00;
    localparam logic [IFG_W-1:0] IFG_RESET = 8'h00;
    // minimum idle words between packets, added to the client adjustment
    localparam logic [IFG_W-1:0] IFG_MIN_WORDS = 8'h01;
    localparam logic VERDICT_BAD = 1'b0;
    localparam logic VERDICT_GOOD = 1'b1;

    // =====================================================================
    // states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_GAP = 2'b10
    } mcs_tx_state_type;

endpackage : mcs_pkg

// >>> src/mcs_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcs_stream_if #(
    parameter int TUSER_W = mcs_pkg::TUSER_W_PLAIN
) (
    input wire logic clk
);
    // transmit: client to device
    logic tx_aresetn;
    logic [mcs_pkg::DATA_W-1:0] tx_tdata;
    logic [mcs_pkg::KEEP_W-1:0] tx_tkeep;
    logic tx_tvalid;
    logic [TUSER_W-1:0] tx_tuser;
    logic tx_tlast;
    logic tx_tready;
    logic [mcs_pkg::IFG_W-1:0] tx_ifg_adjust;
    // receive: device to client, no ready
    logic rx_aresetn;
    logic [mcs_pkg::DATA_W-1:0] rx_tdata;
    logic [mcs_pkg::KEEP_W-1:0] rx_tkeep;
    logic rx_tvalid;
    logic rx_tuser;
    logic rx_tlast;

    modport device (
        input tx_aresetn, tx_tdata, tx_tkeep, tx_tvalid, tx_tuser, tx_tlast,
        input tx_ifg_adjust, rx_aresetn,
        output tx_tready, rx_tdata, rx_tkeep, rx_tvalid, rx_tuser, rx_tlast
    );
    modport client (
        output tx_aresetn, tx_tdata, tx_tkeep, tx_tvalid, tx_tuser, tx_tlast,
        output tx_ifg_adjust, rx_aresetn,
        input tx_tready, rx_tdata, rx_tkeep, rx_tvalid, rx_tuser, rx_tlast
    );
endinterface : mcs_stream_if
`default_nettype wire

// >>> src/mcs_device.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_device #(
    parameter int TUSER_W = mcs_pkg::TUSER_W_PLAIN
) (
    input wire logic clk,
    mcs_stream_if.device bus,
    // line side: transmitted words towards the encoder
    output logic [mcs_pkg::DATA_W-1:0] line_tx_data,
    output logic [mcs_pkg::KEEP_W-1:0] line_tx_keep,
    output logic line_tx_valid,
    output logic line_tx_last,
    output logic line_tx_abort,
    // line side: decoded words from the receiver
    input wire logic [mcs_pkg::DATA_W-1:0] line_rx_data,
    input wire logic [mcs_pkg::KEEP_W-1:0] line_rx_keep,
    input wire logic line_rx_valid,
    input wire logic line_rx_last,
    input wire logic line_rx_fcs_ok
);

    // =====================================================================
    // transmit path
    localparam int LANE_W = mcs_pkg::DATA_W / mcs_pkg::KEEP_W;
    mcs_pkg::mcs_tx_state_type tx_state_r;
    logic [mcs_pkg::IFG_W:0] gap_cnt_r;
    logic [mcs_pkg::IFG_W:0] gap_load;
    logic gap_done;
    logic tx_ready_r;
    logic aborting_r;
    logic tx_take;
    logic tx_take_last;
    logic tx_underrun;

    assign bus.tx_tready = tx_ready_r;
    assign tx_take = bus.tx_tvalid & tx_ready_r;
    assign tx_take_last = tx_take & bus.tx_tlast;
    assign tx_underrun = bus.tx_tuser[mcs_pkg::UNDERRUN_BIT];
    // one spare bit so the largest adjustment plus the minimum cannot wrap
    assign gap_load = {1'b0, bus.tx_ifg_adjust} + {1'b0, mcs_pkg::IFG_MIN_WORDS};
    assign gap_done = (gap_cnt_r <= (mcs_pkg::IFG_W+1)'(1));

    // =====================================================================
    // transmit state
    // a last word goes straight to the gap, whichever state took it
    always_ff @(posedge clk) begin
        if (!bus.tx_aresetn) begin
            tx_state_r <= mcs_pkg::TX_IDLE;
        end else begin
            unique case (tx_state_r)
                mcs_pkg::TX_IDLE: begin
                    if (tx_take_last) begin
                        tx_state_r <= mcs_pkg::TX_GAP;
                    end else if (tx_take) begin
                        tx_state_r <= mcs_pkg::TX_DATA;
                    end
                end
                mcs_pkg::TX_DATA: begin
                    if (tx_take_last) begin
                        tx_state_r <= mcs_pkg::TX_GAP;
                    end
                end
                mcs_pkg::TX_GAP: begin
                    if (gap_done) begin
                        tx_state_r <= mcs_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_state_r <= mcs_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // ready held through the packet so no word is throttled; low only for the gap
    always_ff @(posedge clk) begin
        if (!bus.tx_aresetn) begin
            tx_ready_r <= 1'b0;
        end else if (tx_take_last) begin
            tx_ready_r <= 1'b0;
        end else begin
            unique case (tx_state_r)
                mcs_pkg::TX_IDLE: begin
                    tx_ready_r <= 1'b1;
                end
                mcs_pkg::TX_DATA: begin
                    tx_ready_r <= tx_ready_r;
                end
                mcs_pkg::TX_GAP: begin
                    tx_ready_r <= gap_done;
                end
                default: begin
                    tx_ready_r <= 1'b0;
                end
            endcase
        end
    end

    // idle spacing in words, loaded as the last word is taken
    always_ff @(posedge clk) begin
        if (!bus.tx_aresetn) begin
            gap_cnt_r <= '0;
        end else if (tx_take_last) begin
            gap_cnt_r <= gap_load;
        end else if (tx_state_r == mcs_pkg::TX_GAP) begin
            gap_cnt_r <= gap_done ? '0 : gap_cnt_r - (mcs_pkg::IFG_W+1)'(1);
        end
    end

    // once underrun is seen the rest of the packet is dropped
    always_ff @(posedge clk) begin
        if (!bus.tx_aresetn) begin
            aborting_r <= 1'b0;
        end else if (tx_take) begin
            aborting_r <= (aborting_r | tx_underrun) & ~bus.tx_tlast;
        end
    end

    // =====================================================================
    // transmit line side
    always_ff @(posedge clk) begin
        if (!bus.tx_aresetn) begin
            line_tx_valid <= 1'b0;
            line_tx_last <= 1'b0;
            line_tx_abort <= 1'b0;
        end else begin
            line_tx_valid <= tx_take & ~aborting_r;
            line_tx_last <= tx_take_last & ~aborting_r;
            // the abort pulse rides on the underrun word; the line side closes the frame there
            line_tx_abort <= tx_take & tx_underrun & ~aborting_r;
        end
    end

    // =====================================================================
    // receive path: no ready, each decoded word forwarded next cycle
    always_ff @(posedge clk) begin
        if (!bus.rx_aresetn) begin
            bus.rx_tvalid <= 1'b0;
            bus.rx_tlast <= 1'b0;
            bus.rx_tuser <= mcs_pkg::VERDICT_BAD;
        end else begin
            bus.rx_tvalid <= line_rx_valid;
            bus.rx_tlast <= line_rx_valid & line_rx_last;
            // verdict only meaningful on the last word
            bus.rx_tuser <= (line_rx_valid & line_rx_last & line_rx_fcs_ok)
                ? mcs_pkg::VERDICT_GOOD : mcs_pkg::VERDICT_BAD;
        end
    end

    // =====================================================================
    // byte lanes: each word held lane by lane, qualifier bit i beside lane i
    logic [LANE_W-1:0] tx_lane_data_r [mcs_pkg::KEEP_W];
    logic tx_lane_keep_r [mcs_pkg::KEEP_W];
    logic [LANE_W-1:0] rx_lane_data_r [mcs_pkg::KEEP_W];
    logic rx_lane_keep_r [mcs_pkg::KEEP_W];

    for (genvar i = 0; i < mcs_pkg::KEEP_W; i++) begin : g_lane
        // lanes are captured every cycle; only the valid strobe says they mean anything
        always_ff @(posedge clk) begin
            if (!bus.tx_aresetn) begin
                tx_lane_data_r[i] <= '0;
                tx_lane_keep_r[i] <= 1'b0;
            end else begin
                tx_lane_data_r[i] <= bus.tx_tdata[i*LANE_W +: LANE_W];
                tx_lane_keep_r[i] <= bus.tx_tkeep[i];
            end
        end
        always_ff @(posedge clk) begin
            if (!bus.rx_aresetn) begin
                rx_lane_data_r[i] <= '0;
                rx_lane_keep_r[i] <= 1'b0;
            end else begin
                rx_lane_data_r[i] <= line_rx_data[i*LANE_W +: LANE_W];
                // an idle cycle shows no lanes, so a qualifier never stands without valid
                rx_lane_keep_r[i] <= line_rx_valid & line_rx_keep[i];
            end
        end
    end

    // lanes rejoined into whole words; pure wiring, so the outputs stay registered
    always_comb begin
        for (int i = 0; i < mcs_pkg::KEEP_W; i++) begin
            line_tx_data[i*LANE_W +: LANE_W] = tx_lane_data_r[i];
            line_tx_keep[i] = tx_lane_keep_r[i];
            bus.rx_tdata[i*LANE_W +: LANE_W] = rx_lane_data_r[i];
            bus.rx_tkeep[i] = rx_lane_keep_r[i];
        end
    end

endmodule : mcs_device
`default_nettype wire

// >>> src/mcs_client.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_client #(
    parameter int TUSER_W = mcs_pkg::TUSER_W_PLAIN
) (
    input wire logic clk,
    input wire logic reset,
    mcs_stream_if.client bus,
    // user side transmit: one word per cycle, taken when usr_tx_ready
    input wire logic [mcs_pkg::DATA_W-1:0] usr_tx_data,
    input wire logic [mcs_pkg::KEEP_W-1:0] usr_tx_keep,
    input wire logic usr_tx_valid,
    input wire logic usr_tx_last,
    input wire logic usr_tx_underrun,
    input wire logic [mcs_pkg::IFG_W-1:0] usr_ifg_adjust,
    output logic usr_tx_ready,
    // user side receive
    output logic [mcs_pkg::DATA_W-1:0] usr_rx_data,
    output logic [mcs_pkg::KEEP_W-1:0] usr_rx_keep,
    output logic usr_rx_valid,
    output logic usr_rx_last,
    output logic usr_rx_good,
    output logic usr_rx_bad
);

    // =====================================================================
    // path resets, both released together from the local reset
    logic rst_n_r;
    always_ff @(posedge clk) begin
        rst_n_r <= ~reset;
    end
    assign bus.tx_aresetn = rst_n_r;
    assign bus.rx_aresetn = rst_n_r;

    // =====================================================================
    // transmit: single holding word, refilled as the device takes it
    logic hold_valid_r;
    logic take;
    assign take = hold_valid_r & bus.tx_tready;
    assign usr_tx_ready = ~hold_valid_r | bus.tx_tready;

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_valid_r <= 1'b0;
            bus.tx_tdata <= '0;
            bus.tx_tkeep <= mcs_pkg::KEEP_NONE;
            bus.tx_tlast <= 1'b0;
            bus.tx_tuser <= '0;
            bus.tx_ifg_adjust <= mcs_pkg::IFG_RESET;
        end else begin
            bus.tx_ifg_adjust <= usr_ifg_adjust;
            if (usr_tx_valid && usr_tx_ready) begin
                hold_valid_r <= 1'b1;
                bus.tx_tdata <= usr_tx_data;
                // non-final words are sent with all lanes set
                bus.tx_tkeep <= usr_tx_last ? usr_tx_keep : mcs_pkg::KEEP_FULL;
                bus.tx_tlast <= usr_tx_last;
                bus.tx_tuser <= TUSER_W'(usr_tx_underrun);
            end else if (take) begin
                hold_valid_r <= 1'b0;
            end
        end
    end
    assign bus.tx_tvalid = hold_valid_r;

    // =====================================================================
    // receive: every valid word accepted, nothing can stall it
    always_ff @(posedge clk) begin
        if (reset) begin
            usr_rx_valid <= 1'b0;
            usr_rx_data <= '0;
            usr_rx_keep <= mcs_pkg::KEEP_NONE;
            usr_rx_last <= 1'b0;
            usr_rx_good <= 1'b0;
            usr_rx_bad <= 1'b0;
        end else begin
            usr_rx_valid <= bus.rx_tvalid;
            usr_rx_data <= bus.rx_tdata;
            usr_rx_keep <= bus.rx_tkeep;
            usr_rx_last <= bus.rx_tvalid & bus.rx_tlast;
            usr_rx_good <= bus.rx_tvalid & bus.rx_tlast & (bus.rx_tuser == mcs_pkg::VERDICT_GOOD);
            usr_rx_bad <= bus.rx_tvalid & bus.rx_tlast & (bus.rx_tuser == mcs_pkg::VERDICT_BAD);
        end
    end

endmodule : mcs_client
`default_nettype wire

// >>> tb/mcs_stream_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_stream_assertions (
    input wire logic clk,
    input wire logic tx_aresetn,
    input wire logic [63:0] tx_tdata,
    input wire logic [7:0] tx_tkeep,
    input wire logic tx_tvalid,
    input wire logic tx_tlast,
    input wire logic tx_tready,
    input wire logic [7:0] tx_ifg_adjust,
    input wire logic rx_aresetn,
    input wire logic rx_tvalid
);
    default clocking @(posedge clk);
    endclocking
    logic take;
    logic [8:0] gap_r;
    logic [7:0] ifg_r;
    assign take = tx_tvalid && tx_tready && tx_tlast;
    // ====================================
    // idle cycles since the last word of a packet
    always_ff @(posedge clk) begin
        if (!tx_aresetn || take) gap_r <= 9'h000;
        else if (!tx_tready) gap_r <= gap_r + 9'h001;
    end
    always_ff @(posedge clk) if (take) ifg_r <= tx_ifg_adjust;
    // ====================================
    // assertions
    a_tx_reset_quiet: assert property (!tx_aresetn ##1 !tx_aresetn |-> !tx_tready)
        else $error("tx ready high in reset");
    a_rx_reset_quiet: assert property (!rx_aresetn ##1 !rx_aresetn |-> !rx_tvalid)
        else $error("rx valid high in reset");
    a_ready_at_release: assert property ($rose(tx_aresetn) |=> tx_tready)
        else $error("tx ready late after reset");
    a_ready_drop_last: assert property (disable iff (!tx_aresetn) take |=> !tx_tready)
        else $error("tx ready high after last word");
    a_gap_exact: assert property (disable iff (!tx_aresetn)
        $rose(tx_tready) && $past(tx_aresetn, 2) |-> gap_r == {1'b0, ifg_r} + 9'h001)
        else $error("idle gap length wrong");
    a_no_throttle: assert property (disable iff (!tx_aresetn)
        tx_tready && !take |=> tx_tready) else $error("tx ready dropped in packet");
    a_tx_word_hold: assert property (disable iff (!tx_aresetn)
        tx_tvalid && !tx_tready |=> tx_tvalid && $stable(tx_tdata)) else $error("word not held");
    a_tx_keep_full: assert property (disable iff (!tx_aresetn)
        tx_tvalid && !tx_tlast |-> tx_tkeep == 8'hFF) else $error("partial keep mid packet");
endmodule : mcs_stream_assertions
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TW = mcs_pkg::TUSER_W_PTP;
    logic clk = 1'b0;
    logic reset = 1'b1;
    int mismatches = 0;
    int check_count = 0;
    int seed = 32'hF85F;
    logic [63:0] ud, ld, rd, od;
    logic [7:0] uk, lk, rk, tk, ifg;
    logic uv, ul, uu, ur, lv, ll, lf, rv, rl, rg, rb, ov, ol, oa;
    logic [74:0] txq[$];
    logic [74:0] rxq[$];
    logic [7:0] gaps[3] = '{8'h00, 8'h05, 8'hFF};
    always #25 clk = ~clk;
    mcs_stream_if #(.TUSER_W(TW)) bus (.clk(clk));
    mcs_client #(.TUSER_W(TW)) mcs_client_inst (.clk(clk), .reset(reset), .bus(bus),
        .usr_tx_data(ud), .usr_tx_keep(uk), .usr_tx_valid(uv), .usr_tx_last(ul),
        .usr_tx_underrun(uu), .usr_ifg_adjust(ifg), .usr_tx_ready(ur), .usr_rx_data(rd),
        .usr_rx_keep(rk), .usr_rx_valid(rv), .usr_rx_last(rl), .usr_rx_good(rg), .usr_rx_bad(rb));
    mcs_device #(.TUSER_W(TW)) mcs_device_inst (.clk(clk), .bus(bus), .line_tx_data(od),
        .line_tx_keep(tk), .line_tx_valid(ov), .line_tx_last(ol), .line_tx_abort(oa),
        .line_rx_data(ld), .line_rx_keep(lk), .line_rx_valid(lv), .line_rx_last(ll),
        .line_rx_fcs_ok(lf));
    mcs_stream_assertions mcs_stream_assertions_inst (.clk(clk), .tx_aresetn(bus.tx_aresetn),
        .tx_tdata(bus.tx_tdata), .tx_tkeep(bus.tx_tkeep), .tx_tvalid(bus.tx_tvalid),
        .tx_tlast(bus.tx_tlast), .tx_tready(bus.tx_tready), .tx_ifg_adjust(bus.tx_ifg_adjust),
        .rx_aresetn(bus.rx_aresetn), .rx_tvalid(bus.rx_tvalid));
    // ====================================
    // comparison and verdict
    task check(input logic [74:0] seen, input logic [74:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // ====================================
    // drivers and scoreboards
    task automatic send_pkt(input int n, input int ab);
        int t;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            uv = 1'b1;
            ul = (i == n - 1);
            uu = (i == ab);
            ud = {$random(seed), $random(seed)};
            uk = ul ? 8'hFF >> ($random(seed) & 7) : 8'hFF;
            t = 0;
            #1;
            while (ur !== 1'b1 && t < 300) begin
                @(negedge clk);
                #1;
                t++;
            end
            check(75'(t == 300), 75'h0);
            if (t == 300) results();
            // words after an underrun never reach the line
            if (ab < 0 || i <= ab) txq.push_back({1'b0, uu, ul, uk, ud});
        end
    endtask : send_pkt
    task automatic recv_pkt(input int n);
        for (int i = 1; i <= n; i++) begin
            @(negedge clk);
            if ($random(seed) & 1) begin
                lv = 1'b0;
                @(negedge clk);
            end
            lv = 1'b1;
            ll = (i == n);
            lf = 1'($random(seed));
            ld = {$random(seed), $random(seed)};
            lk = ll ? 8'hFF >> ($random(seed) & 7) : 8'hFF;
            rxq.push_back({ll, ll & lf, ll & !lf, lk, ld});
        end
        @(negedge clk);
        lv = 1'b0;
    endtask : recv_pkt
    always @(negedge clk) begin
        if (ov === 1'b1) check({1'b0, oa, ol, tk, od}, txq.size() > 0 ? txq.pop_front() : 'x);
        if (rv === 1'b1) check({rl, rg, rb, rk, rd}, rxq.size() > 0 ? rxq.pop_front() : 'x);
    end
    initial begin
        {uv, ul, uu, lv, ll, lf} = 6'h00;
        {ud, ld, uk, lk, ifg} = 152'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int k = 0; k < 3; k++) begin
            ifg = gaps[k];
            fork
                begin
                    for (int j = 0; j < 3; j++) send_pkt(1 + j + ($random(seed) & 3), j == 1 ? 1 : -1);
                    @(negedge clk);
                    uv = 1'b0;
                end
                for (int j = 0; j < 3; j++) recv_pkt(1 + ($random(seed) & 7));
            join
            repeat (300) @(negedge clk);
            check(75'(txq.size() + rxq.size()), 75'h0);
            if (k == 1) begin
                reset = 1'b1;
                repeat (3) @(negedge clk);
                check({71'h0, bus.tx_tready, bus.rx_tvalid, ov, rv}, 75'h0);
                reset = 1'b0;
            end
        end
        results();
    end
endmodule : testbench
`default_nettype wire
